// ==== logic/gpio_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module gpio_port
#(
   parameter int NUM_PINS = 8,
   parameter logic [1:0] PORT_ID = 2'h0,
   parameter logic [7:0] AF_RESET_MASK = 8'h00
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire gpio_pkg::bus_req_t bus_req,
   output var logic [31:0] rdata,
   // Pins
   input wire logic [NUM_PINS-1:0] pin_in,
   output var gpio_pkg::pad_t [NUM_PINS-1:0] pad,
   // Peripheral side
   input wire logic [NUM_PINS-1:0] af_out_dflt,
   input wire logic [NUM_PINS-1:0] af_out_remap,
   output var logic [NUM_PINS-1:0] af_in,
   // Interrupt lines
   output var logic [NUM_PINS-1:0] external_interrupt_line
);
   localparam int CFG_BITS = NUM_PINS * gpio_pkg::CFG_W;
   localparam int EXT_BITS = NUM_PINS * gpio_pkg::EXT_SEL_W;

   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   if (NUM_PINS < 1 || NUM_PINS > gpio_pkg::MAX_PINS)
   begin : g_bad_pins
      $error("NUM_PINS must be 1 to 8");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [CFG_BITS-1:0] cfg_reg;
   logic [NUM_PINS-1:0] odr_reg;
   logic [NUM_PINS-1:0] idr_reg;
   logic [NUM_PINS-1:0] locked_reg;
   logic [NUM_PINS-1:0] lock_mask_reg;
   logic [NUM_PINS-1:0] remap_reg;
   logic [EXT_BITS-1:0] ext_sel_reg;
   gpio_pkg::lock_state_t lock_state_reg;
   gpio_pkg::lock_state_t lock_state_next;
   logic [NUM_PINS-1:0] lock_mask_next;
   logic [NUM_PINS-1:0] locked_next;
   logic [31:0] rdata_next;

   logic [NUM_PINS-1:0] pin_sync;
   logic [NUM_PINS-1:0] in_en;
   logic [NUM_PINS-1:0] analog_en;
   gpio_pkg::pad_t [NUM_PINS-1:0] pad_next;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire hit_cfg = (bus_req.addr == gpio_pkg::CFG_OFS);
   wire hit_idr = (bus_req.addr == gpio_pkg::IDR_OFS);
   wire hit_odr = (bus_req.addr == gpio_pkg::ODR_OFS);
   wire hit_lock = (bus_req.addr == gpio_pkg::LOCK_OFS);
   wire hit_ext = (bus_req.addr == gpio_pkg::EXT_OFS);
   wire hit_remap = (bus_req.addr == gpio_pkg::REMAP_OFS);
   wire wr_cfg = bus_req.wr && hit_cfg;
   wire wr_odr = bus_req.wr && hit_odr;
   wire wr_lock = bus_req.wr && hit_lock;
   wire wr_ext = bus_req.wr && hit_ext;
   wire wr_remap = bus_req.wr && hit_remap;
   wire lock_key = bus_req.wdata[gpio_pkg::LOCK_KEY_BIT];
   wire [NUM_PINS-1:0] lock_mask_in = bus_req.wdata[NUM_PINS-1:0];
   wire lock_same = (lock_mask_in == lock_mask_reg);

   // ----------------------------------------
   // Pin input synchroniser
   // ----------------------------------------
   sync_bits #(
      .WIDTH(NUM_PINS)
   ) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   // ----------------------------------------
   // Per-pin configuration and pad control
   // ----------------------------------------
   for (genvar i = 0; i < NUM_PINS; i++)
   begin : g_pin
      localparam logic [3:0] CFG_RST = AF_RESET_MASK[i] ?
         gpio_pkg::CFG_AF_PP : gpio_pkg::CFG_FLOAT_IN;
      wire [3:0] cfg_wr = bus_req.wdata[i*4 +: 4];
      wire [1:0] ext_sel = ext_sel_reg[i*2 +: 2];
      wire cfg_we = wr_cfg && !locked_reg[i];
      wire remap_we = wr_remap && !locked_reg[i];

      // Locked pins ignore configuration writes
      always_ff @(posedge clock or negedge rst_n)
      begin
         if (!rst_n)
         begin
            cfg_reg[i*4 +: 4] <= CFG_RST;
         end
         else if (cfg_we)
         begin
            cfg_reg[i*4 +: 4] <= cfg_wr;
         end
      end

      // A remap write sets the source of every unlocked pin at once
      always_ff @(posedge clock or negedge rst_n)
      begin
         if (!rst_n)
         begin
            remap_reg[i] <= 1'b0;
         end
         else if (remap_we)
         begin
            remap_reg[i] <= bus_req.wdata[i];
         end
      end

      pin_cell u_cell (
         .cfg(cfg_reg[i*4 +: 4]),
         .odr(odr_reg[i]),
         .remap(remap_reg[i]),
         .af_dflt(af_out_dflt[i]),
         .af_remap(af_out_remap[i]),
         .pad(pad_next[i]),
         .in_en(in_en[i])
      );

      assign analog_en[i] = pad_next[i].analog;

      // Line i may only take bit i of whichever port is selected
      always_ff @(posedge clock or negedge rst_n)
      begin
         if (!rst_n)
         begin
            external_interrupt_line[i] <= 1'b0;
         end
         else
         begin
            external_interrupt_line[i] <= (ext_sel == PORT_ID) &&
               idr_reg[i];
         end
      end
   end

   // ----------------------------------------
   // Pad and input data registers
   // ----------------------------------------
   // Registered pad controls keep mode changes free of decode glitches
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int k = 0; k < NUM_PINS; k++)
         begin
            pad[k] <= '{drive: 1'b0, oe_n: 1'b1, pull_up: 1'b0,
               pull_down: 1'b0, schmitt: 1'b1, analog: 1'b0};
         end
      end
      else
      begin
         pad <= pad_next;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         idr_reg <= '0;
      end
      else
      begin
         idr_reg <= pin_sync & ~analog_en;
      end
   end

   // Peripheral input path shares the sampled, Schmitt-side level
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         af_in <= '0;
      end
      else
      begin
         af_in <= pin_sync & in_en;
      end
   end

   // ----------------------------------------
   // Output data, routing select
   // ----------------------------------------
   // Output data stays writable after lock; it is data, not configuration
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         odr_reg <= '0;
      end
      else if (wr_odr)
      begin
         odr_reg <= bus_req.wdata[NUM_PINS-1:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_sel_reg <= {NUM_PINS{gpio_pkg::EXT_NONE}};
      end
      else if (wr_ext)
      begin
         ext_sel_reg <= bus_req.wdata[EXT_BITS-1:0];
      end
   end

   // ----------------------------------------
   // Lock key sequence
   // ----------------------------------------
   // Key 1, key 0, key 1 with the same mask; any deviation restarts
   always_comb
   begin
      lock_state_next = lock_state_reg;
      lock_mask_next = lock_mask_reg;
      locked_next = locked_reg;
      if (wr_lock)
      begin
         case (lock_state_reg)
            gpio_pkg::LK_IDLE:
            begin
               if (lock_key)
               begin
                  lock_state_next = gpio_pkg::LK_ARMED;
                  lock_mask_next = lock_mask_in;
               end
            end
            gpio_pkg::LK_ARMED:
            begin
               lock_state_next = (!lock_key && lock_same) ?
                  gpio_pkg::LK_CONFIRM : gpio_pkg::LK_IDLE;
            end
            gpio_pkg::LK_CONFIRM:
            begin
               lock_state_next = gpio_pkg::LK_IDLE;
               if (lock_key && lock_same)
               begin
                  locked_next = locked_reg | lock_mask_reg;
               end
            end
            default:
            begin
               lock_state_next = gpio_pkg::LK_IDLE;
            end
         endcase
      end
   end

   // Lock flags only ever set; reset is the sole way back
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lock_state_reg <= gpio_pkg::LK_IDLE;
         lock_mask_reg <= '0;
         locked_reg <= '0;
      end
      else
      begin
         lock_state_reg <= lock_state_next;
         lock_mask_reg <= lock_mask_next;
         locked_reg <= locked_next;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Unmapped offsets read as zero rather than aliasing a register
   wire [31:0] rd_cfg = 32'(cfg_reg);
   wire [31:0] rd_idr = 32'(idr_reg);
   wire [31:0] rd_odr = 32'(odr_reg);
   wire [31:0] rd_lock = {15'h0000, |locked_reg, 16'(locked_reg)};
   wire [31:0] rd_ext = 32'(ext_sel_reg);
   wire [31:0] rd_remap = 32'(remap_reg);

   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (bus_req.rd)
      begin
         if (hit_cfg)
         begin
            rdata_next = rd_cfg;
         end
         else if (hit_idr)
         begin
            rdata_next = rd_idr;
         end
         else if (hit_odr)
         begin
            rdata_next = rd_odr;
         end
         else if (hit_lock)
         begin
            rdata_next = rd_lock;
         end
         else if (hit_ext)
         begin
            rdata_next = rd_ext;
         end
         else if (hit_remap)
         begin
            rdata_next = rd_remap;
         end
      end
   end

   // Read data is valid only in the cycle after the strobe
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata <= 32'h0000_0000;
      end
      else
      begin
         rdata <= rdata_next;
      end
   end
endmodule
`default_nettype wire

// ==== common/gpio_pkg.sv ====
// Contract
// - Each pin independently set to any input, output or alternate mode.
// - Each external interrupt line is fed by at most one selected pin.
// - A pin only feeds the interrupt line with its own bit index.
// - Alternate function signals can be rerouted to a second source per pin.
// - A key write sequence freezes selected pin configuration until reset.
// - After reset pins are floating inputs, chosen pins alternate function.
// - Input mode: driver off, pull selectable, no alternate output, no analog.
// - Pin level sampled every clock into input data; read returns it.
// - General output mode: pulls off, Schmitt on, input still sampled.
// - Push-pull output: output data read returns last written value.
// - Alternate mode: driver on, Schmitt on, peripheral lines connected.
// - Alternate mode: output data does not drive; input still sampled.
// - Alternate open-drain reads pin state; push-pull reads output data.
// - Driver source per pin: output data or peripheral signal.
// - Digital input passes the Schmitt stage; analog taps ahead of it.
// - Analog mode: driver, Schmitt, pulls off; input data bit reads zero.
`default_nettype none
package gpio_pkg;
   localparam int MAX_PINS = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CFG_W = 4;
   localparam int EXT_SEL_W = 2;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] CFG_OFS = 8'h00;
   localparam logic [7:0] IDR_OFS = 8'h08;
   localparam logic [7:0] ODR_OFS = 8'h0C;
   localparam logic [7:0] LOCK_OFS = 8'h18;
   localparam logic [7:0] EXT_OFS = 8'h20;
   localparam logic [7:0] REMAP_OFS = 8'h24;
   localparam int LOCK_KEY_BIT = 16;
   // ----------------------------------------
   // Pin configuration fields
   // ----------------------------------------
   localparam int MODE_LSB = 0;
   localparam int CNF_LSB = 2;
   localparam logic [1:0] MODE_IN = 2'h0;
   localparam logic [1:0] CNF_ANALOG = 2'h0;
   localparam logic [1:0] CNF_FLOAT = 2'h1;
   localparam logic [1:0] CNF_PULL = 2'h2;
   localparam logic [3:0] CFG_FLOAT_IN = 4'h4;
   localparam logic [3:0] CFG_AF_PP = 4'hA;
   localparam logic [1:0] EXT_NONE = 2'h3;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
   typedef struct packed {
      logic drive;
      logic oe_n;
      logic pull_up;
      logic pull_down;
      logic schmitt;
      logic analog;
   } pad_t;
   typedef enum logic [2:0] {
      LK_IDLE = 3'b001,
      LK_ARMED = 3'b010,
      LK_CONFIRM = 3'b100
   } lock_state_t;
endpackage
`default_nettype wire

// ==== logic/sync_bits.sv ====
`timescale 1ns/10ps
`default_nettype none
module sync_bits
#(
   parameter int WIDTH = 8
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output var logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // First stage is read only by the second stage
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ==== logic/pin_cell.sv ====
`timescale 1ns/10ps
`default_nettype none
module pin_cell
(
   // Configuration
   input wire logic [3:0] cfg,
   input wire logic odr,
   input wire logic remap,
   // Peripheral drive sources
   input wire logic af_dflt,
   input wire logic af_remap,
   // Pad control and input gating
   output var gpio_pkg::pad_t pad,
   output logic in_en
);
   wire [1:0] mode = cfg[gpio_pkg::MODE_LSB +: 2];
   wire [1:0] cnf = cfg[gpio_pkg::CNF_LSB +: 2];
   wire is_in = (mode == gpio_pkg::MODE_IN);
   wire is_analog = is_in && (cnf == gpio_pkg::CNF_ANALOG);
   wire is_pull = is_in && (cnf == gpio_pkg::CNF_PULL);
   wire is_af = !is_in && cnf[1];
   wire is_od = !is_in && cnf[0];
   wire af_src = remap ? af_remap : af_dflt;
   wire src = is_af ? af_src : odr;

   // Open-drain only enables the driver while pulling low
   assign pad.drive = src;
   assign pad.oe_n = is_in || (is_od && src);
   assign pad.pull_up = is_pull && odr;
   assign pad.pull_down = is_pull && !odr;
   assign pad.schmitt = !is_analog;
   assign pad.analog = is_analog;
   // Peripherals see the pin in input and alternate modes only
   assign in_en = !is_analog && (is_in || is_af);
endmodule
`default_nettype wire

// ==== bench/gpio_port_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module gpio_port_checker
#(
   parameter int NUM_PINS = 8
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Watched ports
   input wire gpio_pkg::bus_req_t bus_req,
   input wire logic [31:0] rdata,
   input wire logic [NUM_PINS-1:0] pin_in,
   input wire gpio_pkg::pad_t [NUM_PINS-1:0] pad,
   input wire logic [NUM_PINS-1:0] af_in,
   input wire logic [NUM_PINS-1:0] external_interrupt_line
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   property p_rd_quiet;
      !$past(bus_req.rd) |-> rdata == 32'h0;
   endproperty
   a_rd_quiet: assert property (p_rd_quiet)
      else $error("read data without a read");
   for (genvar i = 0; i < NUM_PINS; i++)
   begin : g_pin
      property p_reset_in;
         $rose(rst_n) |-> pad[i].oe_n && pad[i].schmitt && !pad[i].analog;
      endproperty
      a_reset_in: assert property (p_reset_in)
         else $error("pin not an input after reset");
      property p_analog;
         pad[i].analog |-> pad[i].oe_n && !pad[i].schmitt
            && !pad[i].pull_up && !pad[i].pull_down;
      endproperty
      a_analog: assert property (p_analog)
         else $error("analog pin has digital parts on");
      property p_analog_in;
         pad[i].analog [*3] |-> !af_in[i];
      endproperty
      a_analog_in: assert property (p_analog_in)
         else $error("analog pin reaches peripheral input");
      property p_drive;
         !pad[i].oe_n |-> pad[i].schmitt && !pad[i].pull_up
            && !pad[i].pull_down;
      endproperty
      a_drive: assert property (p_drive)
         else $error("driven pin has pulls or no input stage");
      property p_pull;
         pad[i].pull_up |-> pad[i].oe_n && !pad[i].pull_down;
      endproperty
      a_pull: assert property (p_pull)
         else $error("pull-up beside driver or pull-down");
      property p_af_src;
         af_in[i] |-> $past(pin_in[i], 3);
      endproperty
      a_af_src: assert property (p_af_src)
         else $error("peripheral input not from its pin");
      property p_line_src;
         external_interrupt_line[i] |-> $past(pin_in[i], 4);
      endproperty
      a_line_src: assert property (p_line_src)
         else $error("interrupt line not from same bit pin");
   end
   c_analog: cover property (pad[0].analog);
   c_drive: cover property (!pad[0].oe_n);
   c_line: cover property (|external_interrupt_line);
endmodule
bind gpio_port gpio_port_checker #(.NUM_PINS(NUM_PINS)) chk_u
(
   .clock(clock),
   .rst_n(rst_n),
   .bus_req(bus_req),
   .rdata(rdata),
   .pin_in(pin_in),
   .pad(pad),
   .af_in(af_in),
   .external_interrupt_line(external_interrupt_line)
);
`default_nettype wire

// ==== bench/pin_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
module pin_partner
#(
   parameter int N = 8
)
(
   // Clock
   input wire logic clock,
   // Pads and board
   input wire gpio_pkg::pad_t [N-1:0] pad,
   input wire logic [N-1:0] ext_en,
   input wire logic [N-1:0] ext_lvl,
   input wire logic ext_pu,
   input wire logic af_hold,
   // Toward the port
   output var logic [N-1:0] pin_in,
   output var logic [N-1:0] af_out_dflt,
   output var logic [N-1:0] af_out_remap
);
   logic [N-1:0] last = '0;
   logic [N-1:0] cnt = '0;
   // A floating pin keeps flipping so no stale level passes for data
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         if (!pad[i].oe_n)
            pin_in[i] = pad[i].drive;
         else if (ext_en[i])
            pin_in[i] = ext_lvl[i];
         else if (ext_pu || pad[i].pull_up)
            pin_in[i] = 1'b1;
         else if (pad[i].pull_down)
            pin_in[i] = 1'b0;
         else
            pin_in[i] = ~last[i];
      end
   end
   always @(posedge clock)
   begin
      last <= pin_in;
      if (!af_hold)
         cnt <= {cnt[N-2:0], ~cnt[N-1]};
   end
   assign af_out_dflt = cnt;
   assign af_out_remap = ~cnt;
endmodule
`default_nettype wire

// ==== bench/test_gpio_pin_mode_and_altfunc.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_gpio_pin_mode_and_altfunc;
   logic clock;
   logic rst_n;
   gpio_pkg::bus_req_t bus_req;
   gpio_pkg::pad_t [7:0] pad;
   logic [31:0] rdata, seed, r, a;
   logic [7:0] pin_in, af_dflt, af_remap, af_in, line, drv, ext_en, ext_lvl;
   logic ext_pu, af_hold, rd_seen;
   logic [3:0] mode_cfg [6] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h5, 4'h9};
   logic [4:0] mode_pad [6] = '{5'h11, 5'h12, 5'h16, 5'h02, 5'h02, 5'h02};
   logic [31:0] exp_q [$];
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   gpio_port dut_u
   (
      .clock(clock),
      .rst_n(rst_n),
      .bus_req(bus_req),
      .rdata(rdata),
      .pin_in(pin_in),
      .pad(pad),
      .af_out_dflt(af_dflt),
      .af_out_remap(af_remap),
      .af_in(af_in),
      .external_interrupt_line(line)
   );
   pin_partner part_u
   (
      .clock(clock),
      .pad(pad),
      .ext_en(ext_en),
      .ext_lvl(ext_lvl),
      .ext_pu(ext_pu),
      .af_hold(af_hold),
      .pin_in(pin_in),
      .af_out_dflt(af_dflt),
      .af_out_remap(af_remap)
   );
   for (genvar i = 0; i < 8; i++) assign drv[i] = pad[i].drive;
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // ----
   // Checking and bus tasks
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      bus_req <= '{ad, d, 1'b1, 1'b0};
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] e);
      exp_q.push_back(e);
      bus_req <= '{ad, 32'h0, 1'b0, 1'b1};
      @(posedge clock);
   endtask
   task automatic idle(input int n);
      bus_req <= '0;
      repeat (n) @(posedge clock);
   endtask
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Read data stand only in the cycle after the strobe
   always @(posedge clock)
   begin
      if (rd_seen)
         chk(rdata, exp_q.pop_front());
      rd_seen <= bus_req.rd;
      cycles++;
      // Whole run needs about a hundred cycles
      if (cycles == 2000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   // ----
   // Main sequence
   // ----
   initial
   begin
      seed = 32'hE18D758A;
      rst_n = 1'b0;
      bus_req = '0;
      ext_en = 8'hFF;
      ext_lvl = 8'h00;
      ext_pu = 1'b0;
      af_hold = 1'b0;
      rd_seen = 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rd(8'h00, 32'h44444444);
      rd(8'h20, 32'h0000FFFF);
      rd(8'h24, 32'h0);
      rd(8'h04, 32'h0);
      r = $random(seed);
      ext_lvl <= r[7:0];
      idle(4);
      rd(8'h08, {24'h0, r[7:0]});
      chk({24'h0, af_in}, {24'h0, r[7:0]});
      $display("Test reset and input done");
      r = $random(seed);
      ext_en <= 8'h00;
      wr(8'h00, 32'h88888888);
      wr(8'h0C, {24'h0, r[7:0]});
      idle(5);
      rd(8'h08, {24'h0, r[7:0]});
      wr(8'h0C, 32'h0);
      foreach (mode_cfg[k])
      begin
         wr(8'h00, {28'h0, mode_cfg[k]});
         idle(2);
         chk({27'h0, pad[0].oe_n, pad[0].pull_up, pad[0].pull_down,
            pad[0].schmitt, pad[0].analog}, {27'h0, mode_pad[k]});
      end
      wr(8'h00, 32'h0);
      idle(3);
      rd(8'h08, 32'h0);
      chk({24'h0, af_in}, 32'h0);
      $display("Test pull and modes done");
      r = $random(seed);
      wr(8'h00, 32'h11111111);
      wr(8'h0C, {24'h0, r[7:0]});
      idle(5);
      rd(8'h0C, {24'h0, r[7:0]});
      rd(8'h08, {24'h0, r[7:0]});
      $display("Test output done");
      wr(8'h00, 32'hAAAAAAAA);
      wr(8'h24, 32'h0F);
      idle(3);
      repeat (4)
      begin
         @(negedge clock);
         a = {24'h0, af_dflt[7:4], af_remap[3:0]};
         @(negedge clock);
         chk({24'h0, drv}, a);
      end
      @(posedge clock);
      rd(8'h0C, {24'h0, r[7:0]});
      af_hold <= 1'b1;
      ext_pu <= 1'b1;
      wr(8'h00, 32'hDDDDDDDD);
      idle(6);
      a = {24'h0, af_dflt[7:4], af_remap[3:0]};
      rd(8'h08, a);
      chk({24'h0, af_in}, a);
      $display("Test alternate drive done");
      r = $random(seed);
      af_hold <= 1'b0;
      ext_pu <= 1'b0;
      ext_en <= 8'hFF;
      ext_lvl <= r[7:0];
      wr(8'h00, 32'h44444444);
      wr(8'h20, 32'h5500);
      idle(6);
      chk({24'h0, line}, {28'h0, r[3:0]});
      $display("Test interrupt lines done");
      wr(8'h18, 32'h10001);
      wr(8'h04, 32'hFFFFFFFF);
      wr(8'h18, 32'h00001);
      wr(8'h18, 32'h10001);
      wr(8'h18, 32'h10002);
      wr(8'h18, 32'h10002);
      wr(8'h18, 32'h00002);
      wr(8'h18, 32'h10002);
      wr(8'h00, 32'h11111111);
      wr(8'h24, 32'h0);
      rd(8'h18, 32'h10001);
      rd(8'h00, 32'h11111114);
      rd(8'h24, 32'h01);
      idle(2);
      rst_n <= 1'b0;
      idle(2);
      rst_n <= 1'b1;
      idle(1);
      rd(8'h18, 32'h0);
      rd(8'h00, 32'h44444444);
      idle(2);
      $display("Test lock done");
      end_of_test();
   end
endmodule
`default_nettype wire
